// ---- hw/gfm_pkg.sv ----
/*
 gauge fieldbus messaging package: message kinds, service and object codes,
 assembly layout, float format fields and timing constants.
 assumes a frame-level CAN controller outside that delivers parsed requests.
*/
package gfm_pkg;

	// object and service codes
	localparam logic [7:0] GFM_CLASS_AOP = 8'h6A;
	localparam logic [7:0] GFM_CLASS_CONN = 8'h05;
	localparam logic [7:0] GFM_INST_COS = 8'h04;
	localparam logic [7:0] GFM_ATTR_PCHG = 8'h64;
	localparam logic [7:0] GFM_ATTR_AOMODE = 8'h65;
	localparam logic [7:0] GFM_SVC_GET = 8'h0E;
	localparam logic [7:0] GFM_SVC_SET = 8'h10;
	localparam logic [7:0] GFM_ERR_SVC = 8'h08;
	localparam logic [7:0] GFM_ERR_ATTR = 8'h14;
	localparam logic [7:0] GFM_ERR_VALUE = 8'h09;
	localparam logic [7:0] GFM_ERR_OBJ = 8'h16;
	localparam logic [7:0] GFM_OK = 8'h00;
	localparam logic [7:0] GFM_AOMODE_LOG = 8'h00;

	// threshold range in percent
	localparam logic [7:0] GFM_PCHG_MIN = 8'h01;
	localparam logic [7:0] GFM_PCHG_MAX = 8'h64;
	localparam logic [7:0] GFM_PCHG_RST = 8'h0A;

	// float fields
	localparam int GFM_SIGN_POS = 31;
	localparam int GFM_EXP_LSB = 23;
	localparam int GFM_FRAC_W = 23;
	localparam logic [7:0] GFM_EXP_BIAS = 8'h7F;

	// assembly layout
	localparam int GFM_ASM_BYTES = 6;
	localparam int GFM_ASM_PRES_LO = 2;
	localparam logic [7:0] GFM_ASM_FULL = 8'h01;
	localparam logic [7:0] GFM_ASM_SHORT = 8'h03;

	// recommended master poll spacing
	localparam int GFM_SCAN_MS = 20;
	localparam int GFM_CLK_MHZ = 100;
	localparam int GFM_SCAN_CYC = GFM_SCAN_MS * 1000 * GFM_CLK_MHZ;

	typedef enum logic [2:0] {
		GFM_MSG_POLL,
		GFM_MSG_STROBE,
		GFM_MSG_EXPLICIT,
		GFM_MSG_CYCLIC,
		GFM_MSG_COS
	} gfm_msg_t;

	typedef struct packed {
		gfm_msg_t kind;
		logic strobe_bit;
		logic [7:0] service;
		logic [7:0] class_id;
		logic [7:0] instance_id;
		logic [7:0] attr_id;
		logic [7:0] data;
	} gfm_req_t;

	typedef struct packed {
		gfm_msg_t kind;
		logic [7:0] asm_id;
		logic [7:0] status;
		logic [7:0] data;
		logic [47:0] assembly;
	} gfm_rsp_t;

endpackage

// ---- hw/gfm_float_enc.sv ----
/*
 unsigned fixed-point to single-precision converter, one cycle of latency.
 assumes the input is a non-negative integer of mantissa units times 2^-FRAC.
*/
`timescale 1ns/10ps
module gfm_float_enc
	import gfm_pkg::*;
#(
	parameter int IN_W = 32,
	parameter int FRAC = 16
) (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic clk_en_i,
	input wire logic sign_i,
	input wire logic [IN_W-1:0] mag_i,
	output logic [31:0] flt_o
);

	logic [31:0] flt_reg;
	logic [31:0] flt_next;

	////////////////////////////////////////////////////////////////////////
	// leading-one search then normalise; zero maps to +/-0
	always_comb begin
		int lead;
		logic [IN_W-1:0] norm;
		lead = -1;
		norm = '0;
		for (int i = 0; i < IN_W; i++) begin
			if (mag_i[i]) begin
				lead = i;
			end
		end
		flt_next = '0;
		flt_next[GFM_SIGN_POS] = sign_i;
		if (lead >= 0) begin
			norm = mag_i << (IN_W - 1 - lead);
			// biased exponent, hidden one dropped from the fraction
			flt_next[30:GFM_EXP_LSB] = 8'(lead - FRAC + int'(GFM_EXP_BIAS));
			flt_next[GFM_FRAC_W-1:0] = norm[IN_W-2 -: GFM_FRAC_W];
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			flt_reg <= 32'h0000_0000;
		end else if (clk_en_i) begin
			flt_reg <= flt_next;
		end
	end

	assign flt_o = flt_reg;

endmodule

// ---- hw/gfm_msg_core.sv ----
/*
 gauge fieldbus slave messaging core: answers polls, bit strobes and
 explicit get/set requests, and raises change-of-state reports.
 assumes a link layer that hands over one parsed request per req_valid_i
 pulse and takes one answer per rsp_valid_o pulse; the pressure input and
 its sign come from the measuring chain on the same clock.
// Overview of operation
// - analog output point object lives at class 6A hex, no class attributes.
// - get single 0E and set single 10 are accepted on that object.
// - group-two-only slave: poll, strobe, change-of-state/cyclic, explicit.
// - high voltage is switched via this slave's bit-strobe bit.
// - strobe bit 1 turns high voltage on, reply with input assembly 1.
// - strobe bit 0 turns high voltage off.
// - threshold byte is attribute 100, class 5 instance 4, read and write.
// - send change-of-state when value deviates by threshold percent.
// - threshold valid only 1 to 100 percent; all of them supported.
// - real values go out as 32-bit single-precision floats.
// - top bit is sign, 1 negative, 0 positive.
// - eight exponent bits hold exponent plus bias 127.
// - low 23 bits are fraction without hidden leading one.
// - pressure bytes sit at assembly bytes 2..5, low byte first.
*/
`timescale 1ns/10ps
module gfm_msg_core
	import gfm_pkg::*;
#(
	parameter int PRES_W = 32,
	parameter int PRES_FRAC = 16
) (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic clk_en_i,
	input wire logic req_valid_i,
	input wire gfm_req_t req_i,
	input wire logic pres_sign_i,
	input wire logic [PRES_W-1:0] pres_mag_i,
	input wire logic sensor_ok_i,
	input wire logic [7:0] exc_status_i,
	output gfm_rsp_t rsp_o,
	output logic rsp_valid_o,
	output logic gauge_high_voltage_o,
	output logic [7:0] pchg_o
);

	////////////////////////////////////////////////////////////////////////
	// state
	logic hv_reg;
	logic hv_next;
	logic [7:0] pchg_reg;
	logic [7:0] pchg_next;
	logic [PRES_W-1:0] ref_reg;
	logic [PRES_W-1:0] ref_next;
	logic ref_sign_reg;
	logic ref_sign_next;
	logic rsp_valid_reg;
	logic rsp_valid_next;
	gfm_rsp_t rsp_reg;
	gfm_rsp_t rsp_next;
	logic pend_reg;
	logic pend_next;
	logic [31:0] flt;

	// float conversion of the live pressure, one cycle behind the input
	gfm_float_enc #(
		.IN_W(PRES_W),
		.FRAC(PRES_FRAC)
	) u_enc (
		.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.clk_en_i(clk_en_i),
		.sign_i(pres_sign_i),
		.mag_i(pres_mag_i),
		.flt_o(flt)
	);

	////////////////////////////////////////////////////////////////////////
	// helpers

	// status byte 0 of the input assemblies
	function automatic logic [7:0] status_byte(input logic hv, input logic ok);
		status_byte = {5'h00, 1'b1, hv, ok};
	endfunction

	// full input assembly: status, exception, float low byte first
	function automatic logic [47:0] full_asm(input logic [7:0] st, input logic [7:0] ex,
		input logic [31:0] f);
		full_asm = {f[31:24], f[23:16], f[15:8], f[7:0], ex, st};
	endfunction

	// deviation test: |now - ref| * 100 >= ref * pct
	function automatic logic deviates(input logic [PRES_W-1:0] now,
		input logic [PRES_W-1:0] ref_v, input logic [7:0] pct);
		logic [PRES_W-1:0] diff;
		logic [PRES_W+7:0] lhs;
		logic [PRES_W+7:0] rhs;
		diff = (now > ref_v) ? (now - ref_v) : (ref_v - now);
		lhs = (PRES_W+8)'(diff) * (PRES_W+8)'(GFM_PCHG_MAX);
		rhs = (PRES_W+8)'(ref_v) * (PRES_W+8)'(pct);
		deviates = (lhs >= rhs) && (diff != '0);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// request decode and next state
	always_comb begin
		logic [7:0] st;
		logic [7:0] code;
		logic [7:0] dat;
		st = status_byte(hv_reg, sensor_ok_i);
		code = GFM_OK;
		dat = 8'h00;
		hv_next = hv_reg;
		pchg_next = pchg_reg;
		ref_next = ref_reg;
		ref_sign_next = ref_sign_reg;
		rsp_valid_next = 1'b0;
		rsp_next = rsp_reg;
		pend_next = pend_reg;
		// change detection runs on every cycle, reported when link is idle
		if (deviates(pres_mag_i, ref_reg, pchg_reg) || (pres_sign_i != ref_sign_reg)) begin
			pend_next = 1'b1;
		end
		if (req_valid_i) begin
			case (req_i.kind)
				GFM_MSG_STROBE: begin
					hv_next = req_i.strobe_bit;
					if (req_i.strobe_bit) begin
						// reply carries the new high-voltage state
						rsp_next.asm_id = GFM_ASM_FULL;
						rsp_next.assembly = full_asm(status_byte(1'b1, sensor_ok_i),
							exc_status_i, flt);
						rsp_valid_next = 1'b1;
					end // strobe 0 only turns off, no reply
				end
				GFM_MSG_POLL, GFM_MSG_CYCLIC: begin
					rsp_next.asm_id = GFM_ASM_FULL;
					rsp_next.assembly = full_asm(st, exc_status_i, flt);
					rsp_valid_next = 1'b1;
				end
				GFM_MSG_EXPLICIT: begin
					if (req_i.class_id == GFM_CLASS_AOP) begin
						if (req_i.instance_id == 8'h00) begin
							code = GFM_ERR_ATTR; // no class attributes
						end else if (req_i.service == GFM_SVC_GET) begin
							if (req_i.attr_id == GFM_ATTR_AOMODE) begin
								dat = GFM_AOMODE_LOG;
							end else begin
								code = GFM_ERR_ATTR;
							end
						end else if (req_i.service == GFM_SVC_SET) begin
							// the only attribute here is read-only
							code = GFM_ERR_ATTR;
						end else begin
							code = GFM_ERR_SVC;
						end
					end else if (req_i.class_id == GFM_CLASS_CONN &&
						req_i.instance_id == GFM_INST_COS &&
						req_i.attr_id == GFM_ATTR_PCHG) begin
						if (req_i.service == GFM_SVC_GET) begin
							dat = pchg_reg;
						end else if (req_i.service == GFM_SVC_SET) begin
							// out-of-range values refused, old threshold kept
							if (req_i.data >= GFM_PCHG_MIN && req_i.data <= GFM_PCHG_MAX) begin
								pchg_next = req_i.data;
							end else begin
								code = GFM_ERR_VALUE;
							end
						end else begin
							code = GFM_ERR_SVC;
						end
					end else begin
						code = GFM_ERR_OBJ;
					end
					rsp_next.asm_id = 8'h00;
					rsp_next.assembly = '0;
					rsp_next.status = code;
					rsp_next.data = dat;
					rsp_valid_next = 1'b1;
				end
				default: begin
					rsp_valid_next = 1'b0;
				end
			endcase
			rsp_next.kind = req_i.kind;
		end else if (pend_reg) begin
			// report and take this value as the new reference
			rsp_next.kind = GFM_MSG_COS;
			rsp_next.asm_id = GFM_ASM_FULL;
			rsp_next.status = GFM_OK;
			rsp_next.data = 8'h00;
			rsp_next.assembly = full_asm(st, exc_status_i, flt);
			rsp_valid_next = 1'b1;
			ref_next = pres_mag_i;
			ref_sign_next = pres_sign_i;
			pend_next = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			hv_reg <= 1'b0;
			pchg_reg <= GFM_PCHG_RST;
			ref_reg <= '0;
			ref_sign_reg <= 1'b0;
			rsp_valid_reg <= 1'b0;
			rsp_reg <= '0;
			pend_reg <= 1'b0;
		end else if (clk_en_i) begin
			hv_reg <= hv_next;
			pchg_reg <= pchg_next;
			ref_reg <= ref_next;
			ref_sign_reg <= ref_sign_next;
			rsp_valid_reg <= rsp_valid_next;
			rsp_reg <= rsp_next;
			pend_reg <= pend_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs straight from flip-flops
	assign rsp_o = rsp_reg;
	assign rsp_valid_o = rsp_valid_reg;
	assign gauge_high_voltage_o = hv_reg;
	assign pchg_o = pchg_reg;

endmodule

// ---- test/gfm_master_model.sv ----
/*
 fieldbus master model: sends one parsed request per call of send.
 assumes one calling process and a free-running clock.
*/
`timescale 1ns/10ps
module gfm_master_model
	import gfm_pkg::*;
#(
	parameter int GAP = 2
) (
	input wire logic sys_clk_i,
	output logic req_valid_o,
	output gfm_req_t req_o
);
	initial begin
		req_valid_o = 1'b0;
		req_o = '0;
	end
	////////////////////////////////////////////////////////////
	// one-cycle pulse; released fields are inverted so stale data is never trusted
	task automatic send(input gfm_req_t r);
		@(posedge sys_clk_i);
		#1;
		req_valid_o = 1'b1;
		req_o = r;
		@(posedge sys_clk_i);
		#1;
		req_valid_o = 1'b0;
		req_o = ~r;
		repeat (GAP) @(posedge sys_clk_i);
		#1;
	endtask
endmodule

// ---- test/gfm_msg_checker.sv ----
/*
 checker for the messaging core, fed from its ports only.
 assumes a bind from the bench and the pressure sign held around polls.
*/
`timescale 1ns/10ps
module gfm_msg_checker
	import gfm_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic clk_en_i,
	input wire logic req_valid_i,
	input wire gfm_req_t req_i,
	input wire logic pres_sign_i,
	input wire gfm_rsp_t rsp_o,
	input wire logic rsp_valid_o,
	input wire logic gauge_high_voltage_o,
	input wire logic [7:0] pchg_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	////////////////////////////////////////////////////////////
	// request shapes shared by the properties
	sequence s_req(gfm_msg_t k); clk_en_i && req_valid_i && req_i.kind == k; endsequence
	sequence s_pset;
		s_req(GFM_MSG_EXPLICIT) ##0 req_i.service == GFM_SVC_SET && req_i.attr_id == GFM_ATTR_PCHG
			&& req_i.class_id == GFM_CLASS_CONN && req_i.instance_id == GFM_INST_COS;
	endsequence
	sequence s_cos; rsp_valid_o && rsp_o.kind == GFM_MSG_COS; endsequence
	////////////////////////////////////////////////////////////
	// answers tied to their requests one cycle earlier
	property p_hv_on; s_req(GFM_MSG_STROBE) ##0 req_i.strobe_bit |=> gauge_high_voltage_o
		&& rsp_valid_o && rsp_o.asm_id == GFM_ASM_FULL && rsp_o.assembly[1]; endproperty
	a_hv_on: assert property (p_hv_on) else $error("strobe one reply wrong");
	property p_hv_off; s_req(GFM_MSG_STROBE) ##0 !req_i.strobe_bit
		|=> !gauge_high_voltage_o && !rsp_valid_o; endproperty
	a_hv_off: assert property (p_hv_off) else $error("strobe zero left high voltage");
	property p_poll; s_req(GFM_MSG_POLL) |=> rsp_valid_o && rsp_o.asm_id == GFM_ASM_FULL
		&& rsp_o.assembly[2:1] == {1'b1, gauge_high_voltage_o}; endproperty
	a_poll: assert property (p_poll) else $error("poll reply wrong");
	// the float lags the pressure input by the encoder stage
	property p_sign; s_req(GFM_MSG_POLL) |=> rsp_o.assembly[47] == $past(pres_sign_i, 2); endproperty
	a_sign: assert property (p_sign) else $error("sign bit wrong");
	property p_set_ok; s_pset ##0 req_i.data inside {[GFM_PCHG_MIN:GFM_PCHG_MAX]}
		|=> rsp_o.status == GFM_OK && pchg_o == $past(req_i.data); endproperty
	a_set_ok: assert property (p_set_ok) else $error("threshold write lost");
	property p_set_bad; s_pset ##0 !(req_i.data inside {[GFM_PCHG_MIN:GFM_PCHG_MAX]})
		|=> rsp_o.status == GFM_ERR_VALUE && $stable(pchg_o); endproperty
	a_set_bad: assert property (p_set_bad) else $error("bad threshold taken");
	property p_aop; s_req(GFM_MSG_EXPLICIT) ##0 req_i.service == GFM_SVC_GET
		&& req_i.class_id == GFM_CLASS_AOP && req_i.attr_id == GFM_ATTR_AOMODE
		&& req_i.instance_id == 8'h01 |=> rsp_valid_o && rsp_o.status == GFM_OK
		&& rsp_o.data == GFM_AOMODE_LOG; endproperty
	a_aop: assert property (p_aop) else $error("output mode read wrong");
	// reports never steal a request cycle
	property p_cos_idle; s_cos |-> !$past(req_valid_i); endproperty
	a_cos_idle: assert property (p_cos_idle) else $error("report on request cycle");
endmodule

// ---- test/gfm_msg_core_bench.sv ----
/*
 bench for the messaging core: polls, strobes, explicit access, reports.
 assumes the master model and the checker bound below.
*/
`timescale 1ns/10ps
module gfm_msg_core_bench import gfm_pkg::*;;
	typedef struct packed {logic [1:0] m; gfm_rsp_t r;} gfm_note_t;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic sgn = 1'b0;
	logic ok = 1'b1;
	logic [7:0] exc = 8'h00;
	logic [31:0] mag = 32'h0;
	logic rv, rsp_v, hv;
	logic [7:0] pchg;
	gfm_req_t req;
	gfm_rsp_t rsp;
	gfm_note_t n;
	gfm_note_t notes[$];
	int fails = 0, samples_checked = 0, cos_seen = 0, cyc = 0, seed = 32'h452BCDE9;
	always #5 clk = ~clk;
	gfm_master_model #(.GAP(2)) master (.sys_clk_i(clk), .req_valid_o(rv), .req_o(req));
	gfm_msg_core dut (.sys_clk_i(clk), .reset_n_i(rst_n), .clk_en_i(1'b1), .req_valid_i(rv),
		.req_i(req), .pres_sign_i(sgn), .pres_mag_i(mag), .sensor_ok_i(ok), .exc_status_i(exc),
		.rsp_o(rsp), .rsp_valid_o(rsp_v), .gauge_high_voltage_o(hv), .pchg_o(pchg));
	////////////////////////////////////////////////////////////
	task automatic check(input logic [47:0] seen, want);
		samples_checked++;
		if (seen !== want) begin
			fails++;
			$display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// answers matched oldest first; reports come unasked, so they are only counted
	always @(negedge clk) begin
		if (rsp_v === 1'b1 && rsp.kind === GFM_MSG_COS) cos_seen++;
		else if (rsp_v === 1'b1) begin
			check(48'(notes.size() != 0), 48'h1);
			n = notes.pop_front();
			check(48'(rsp.asm_id), 48'(n.r.asm_id));
			if (n.m == 2'h1) check(rsp.assembly, n.r.assembly);
			else check({rsp.status, n.m == 2'h2 ? rsp.data : 8'h00}, {n.r.status, n.r.data});
		end
	end
	// hang guard, far above the roughly 160 cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			fails++;
			give_verdict();
		end
	end
	////////////////////////////////////////////////////////////
	// full-assembly request with the pressure settled first
	task automatic ask(input gfm_msg_t k, input logic s, input logic [31:0] m, f, input logic h);
		sgn = s;
		mag = m;
		ok = 1'($random(seed));
		exc = 8'($random(seed));
		repeat (3) @(posedge clk);
		notes.push_back({2'h1, k, GFM_ASM_FULL, 16'h0, f, exc, 5'h00, 1'b1, h, ok});
		master.send({k, h, 40'h0});
	endtask
	task automatic ex(input logic [7:0] svc, cls, att, d, st, rd, input logic [1:0] md);
		notes.push_back({md, GFM_MSG_EXPLICIT, 8'h00, st, rd, 48'h0});
		master.send({GFM_MSG_EXPLICIT, 1'b0, svc, cls,
			cls == GFM_CLASS_CONN ? GFM_INST_COS : 8'h01, att, d});
	endtask
	task automatic pc(input logic [7:0] svc, d, st, rd, input logic [1:0] md);
		ex(svc, GFM_CLASS_CONN, GFM_ATTR_PCHG, d, st, rd, md);
	endtask
	task automatic cos_step(input logic s, input logic [31:0] m, input int want);
		int base;
		base = cos_seen;
		sgn = s;
		mag = m;
		repeat (8) @(posedge clk);
		#1;
		check(48'(cos_seen - base), 48'(want));
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clk);
		#1;
		rst_n = 1'b1;
		ask(GFM_MSG_POLL, 1'b1, 32'h000C8000, 32'hC1480000, 1'b0);
		ask(GFM_MSG_POLL, 1'b0, 32'h00000000, 32'h00000000, 1'b0);
		ask(GFM_MSG_POLL, 1'b0, 32'h00000001, 32'h37800000, 1'b0);
		ask(GFM_MSG_POLL, 1'b0, 32'hFFFFFFFF, 32'h477FFFFF, 1'b0);
		$display("poll test done");
		ask(GFM_MSG_STROBE, 1'b0, 32'h00018000, 32'h3FC00000, 1'b1);
		check(48'(hv), 48'h1);
		master.send({GFM_MSG_STROBE, 41'h0});
		check(48'(hv), 48'h0);
		ask(GFM_MSG_POLL, 1'b0, 32'h00010000, 32'h3F800000, 1'b0);
		ask(GFM_MSG_CYCLIC, 1'b0, 32'h00010000, 32'h3F800000, 1'b0);
		$display("strobe test done");
		pc(GFM_SVC_GET, 8'h00, GFM_OK, GFM_PCHG_RST, 2'h2);
		pc(GFM_SVC_SET, 8'h00, GFM_ERR_VALUE, 8'h00, 2'h3);
		pc(GFM_SVC_SET, 8'h65, GFM_ERR_VALUE, 8'h00, 2'h3);
		pc(GFM_SVC_SET, 8'h01, GFM_OK, 8'h00, 2'h3);
		pc(GFM_SVC_SET, 8'h64, GFM_OK, 8'h00, 2'h3);
		pc(GFM_SVC_GET, 8'h00, GFM_OK, 8'h64, 2'h2);
		pc(GFM_SVC_SET, 8'h32, GFM_OK, 8'h00, 2'h3);
		check(48'(pchg), 48'h32);
		ex(GFM_SVC_GET, GFM_CLASS_AOP, GFM_ATTR_AOMODE, 8'h00, GFM_OK, GFM_AOMODE_LOG, 2'h2);
		ex(GFM_SVC_SET, GFM_CLASS_AOP, GFM_ATTR_AOMODE, 8'h00, GFM_ERR_ATTR, 8'h00, 2'h3);
		ex(8'h05, GFM_CLASS_AOP, GFM_ATTR_AOMODE, 8'h00, GFM_ERR_SVC, 8'h00, 2'h3);
		ex(GFM_SVC_GET, 8'h67, GFM_ATTR_AOMODE, 8'h00, GFM_ERR_OBJ, 8'h00, 2'h3);
		$display("explicit test done");
		cos_step(1'b0, 32'h00100000, 1);
		cos_step(1'b0, 32'h0011999A, 0);
		cos_step(1'b0, 32'h00180000, 1);
		cos_step(1'b0, 32'h00100000, 0);
		cos_step(1'b1, 32'h00100000, 1);
		$display("report test done");
		repeat (5) @(posedge clk);
		check(48'(notes.size()), 48'h0);
		give_verdict();
	end
endmodule
bind gfm_msg_core gfm_msg_checker chk (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
	.clk_en_i(clk_en_i), .req_valid_i(req_valid_i), .req_i(req_i), .pres_sign_i(pres_sign_i),
	.rsp_o(rsp_o), .rsp_valid_o(rsp_valid_o), .gauge_high_voltage_o(gauge_high_voltage_o),
	.pchg_o(pchg_o));
